// ==== rtl/fle_device.sv ====
/*
  Device end: fuse/lock readback for the CPU and the data EEPROM
  written over the parallel programming link.
  Assumes the CPU raises cpu_lpm_i for one cycle per load instruction
  and that the programmer keeps to the load/strobe order of the link.
*/
`timescale 1ns/1ps
module fle_device #(
  parameter int EE_ADDR_W = 9,                   // EEPROM address width
  parameter int WRITE_CYC = fle_pkg::EE_WRITE_CYC // Byte write time in cycles
) (
  input  wire logic                 clk_i,              // Clock
  input  wire logic                 rst_i,              // Synchronous reset, high
  input  wire logic                 ce_i,               // Clock enable
  fle_pp_if.device                  pp,                 // Programming link
  input  wire logic                 cpu_ctl_wr_i,       // Write to self_prog_control_reg
  input  wire logic [7:0]           cpu_ctl_wdata_i,    // Control write data
  input  wire logic                 cpu_lpm_i,          // program_memory_load_instr pulse
  input  wire logic                 cpu_spm_i,          // Store-program instruction pulse
  input  wire logic [15:0]          cpu_z_i,            // Z index pointer
  input  wire logic [5:0]           lock_prog_i,        // Lock bits, 1 = programmed
  input  wire logic [6:0]           fuse_prog_i,        // Fuse bits, 1 = programmed
  input  wire logic [EE_ADDR_W-1:0] ee_raddr_i,         // EEPROM read address
  output logic [7:0]                ee_rdata_o,         // EEPROM read data
  output logic [7:0]                cpu_rdata_o,        // Load result
  output logic                      cpu_rvalid_o,       // Load result valid pulse
  output logic                      lock_access_bit_o,  // Control bit state
  output logic                      self_prog_enable_o  // Control bit state
);
  // Refuse sizes that the address concatenation or the counter cannot serve
  if (EE_ADDR_W != 9 || WRITE_CYC < 1)
  begin : g_param_check
    $error("fle_device: unsupported parameter values");
  end

  typedef enum logic [0:0] {
    FLE_IDLE_ST = 1'b0,
    FLE_BUSY_ST = 1'b1
  } fle_pstate_type;

  logic [7:0]           ee_mem [2**EE_ADDR_W];   // EEPROM array
  fle_pstate_type       pst_q;                   // Programming state
  logic [7:0]           cmd_q;                   // Loaded command
  logic                 addr_hi_q;               // Upper address bit
  logic [7:0]           addr_lo_q;               // Lower address bits
  logic [7:0]           data_lo_q;               // Data low byte
  logic                 wr_n_q;                  // Previous strobe level
  logic [15:0]          wcnt_q;                  // Write time counter
  logic                 rdy_q;                   // Ready/busy flop
  logic [1:0]           rbcnt_q;                 // Readback window counter
  logic                 strobe;                  // Falling strobe edge
  logic                 arm;                     // Both control bits set
  logic [7:0]           lock_byte;               // Assembled lock readback
  logic [7:0]           fuse_byte;               // Assembled fuse readback

  assign strobe = wr_n_q && !pp.pp_wr_n;
  assign pp.ready_busy_out = rdy_q;
  assign arm = lock_access_bit_o && self_prog_enable_o;

  // Lock byte, programmed bits inverted to read as zero
  always_comb
  begin
    lock_byte = 8'hFF;
    lock_byte[fle_pkg::LOCK_BOOT_LSB +: 4] = ~lock_prog_i[5:2];
    lock_byte[fle_pkg::LOCK_MEM_LSB +: 2]  = ~lock_prog_i[1:0];
  end

  // Fuse byte, unused bits 7 and 3 read as one
  always_comb
  begin
    fuse_byte = 8'hFF;
    fuse_byte[fle_pkg::FUSE_VEC_POS]      = ~fuse_prog_i[6];
    fuse_byte[fle_pkg::FUSE_SER_POS]      = ~fuse_prog_i[5];
    fuse_byte[fle_pkg::FUSE_SUT_POS]      = ~fuse_prog_i[4];
    fuse_byte[fle_pkg::FUSE_CLK_LSB +: 3] = ~fuse_prog_i[2:0];
  end

  // Strobe edge history
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wr_n_q <= 1'b1;
    else if (ce_i)
      wr_n_q <= pp.pp_wr_n;
  end

  // Load latches, frozen while a write runs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cmd_q     <= 8'h00;
      addr_hi_q <= 1'b0;
      addr_lo_q <= 8'h00;
      data_lo_q <= 8'hFF;
    end
    else if (ce_i && pp.pp_load && pst_q == FLE_IDLE_ST)
    begin
      case (pp.pp_load_sel)
        fle_pkg::LD_CMD:     cmd_q     <= pp.pp_data;
        fle_pkg::LD_ADDR_HI: addr_hi_q <= pp.pp_data[0];
        fle_pkg::LD_ADDR_LO: addr_lo_q <= pp.pp_data;
        fle_pkg::LD_DATA_LO: data_lo_q <= pp.pp_data;
        default:             cmd_q     <= cmd_q;
      endcase
    end
  end

  // Programming sequencer and ready/busy
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pst_q  <= FLE_IDLE_ST;
      wcnt_q <= 16'h0000;
      rdy_q  <= 1'b1;
    end
    else if (ce_i)
    begin
      case (pst_q)
        FLE_IDLE_ST:
        begin
          rdy_q <= 1'b1;
          // Accept a strobe only for a write command with low byte picked
          if (strobe && cmd_q == fle_pkg::CMD_EE_WRITE && !pp.byte_select)
          begin
            pst_q  <= FLE_BUSY_ST;
            wcnt_q <= 16'(WRITE_CYC - 1);
            rdy_q  <= 1'b0;
          end
        end
        FLE_BUSY_ST:
        begin
          // Further strobes are not looked at here
          if (wcnt_q == 16'h0000)
          begin
            pst_q <= FLE_IDLE_ST;
            rdy_q <= 1'b1;
          end
          else
            wcnt_q <= wcnt_q - 16'h0001;
        end
        default:
        begin
          pst_q <= FLE_IDLE_ST;
          rdy_q <= 1'b1;
        end
      endcase
    end
  end

  // Array write when the byte is committed, read port registered
  always_ff @(posedge clk_i)
  begin
    if (ce_i && pst_q == FLE_BUSY_ST && wcnt_q == 16'h0000)
      ee_mem[{addr_hi_q, addr_lo_q}] <= data_lo_q;
    if (rst_i)
      ee_rdata_o <= 8'h00;
    else if (ce_i)
      ee_rdata_o <= ee_mem[ee_raddr_i];
  end

  // Control bits and readback window
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lock_access_bit_o  <= 1'b0;
      self_prog_enable_o <= 1'b0;
      rbcnt_q            <= 2'h0;
      cpu_rdata_o        <= 8'h00;
      cpu_rvalid_o       <= 1'b0;
    end
    else if (ce_i)
    begin
      cpu_rvalid_o <= 1'b0;
      if (cpu_ctl_wr_i && pst_q == FLE_IDLE_ST)
      begin
        // Setting is refused while an EEPROM write runs
        lock_access_bit_o  <= cpu_ctl_wdata_i[fle_pkg::CTL_LOCK_ACC_POS];
        self_prog_enable_o <= cpu_ctl_wdata_i[fle_pkg::CTL_SELF_PROG_POS];
        rbcnt_q            <= 2'h0;
      end
      else if (arm)
      begin
        if (cpu_lpm_i)
        begin
          // Pointer picks fuse or lock byte
          cpu_rdata_o        <= (cpu_z_i == fle_pkg::Z_LOCK) ? lock_byte : fuse_byte;
          cpu_rvalid_o       <= 1'b1;
          lock_access_bit_o  <= 1'b0;
          self_prog_enable_o <= 1'b0;
        end
        else if (cpu_spm_i || rbcnt_q == 2'(fle_pkg::RB_WINDOW - 1))
        begin
          lock_access_bit_o  <= 1'b0;
          self_prog_enable_o <= 1'b0;
        end
        else
          rbcnt_q <= rbcnt_q + 2'h1;
      end
    end
  end
endmodule : fle_device

// ==== rtl/fle_pkg.sv ====
/*
  Shared constants for the fuse/lock readback and the data EEPROM
  parallel programming link: load codes, command, field positions,
  bus offsets and timing counts.
  Assumes a single 250 MHz clock shared by both ends of the link.
*/
// Operation
// - Software loads pointer one before lock readback
// - Software loads pointer zero before fuse readback
// - Load within three cycles returns selected bits
// - Control bits self-clear on completion or timeout
// - Lock byte: boot bits 5:2, lock 1:0
// - Fuse byte: vector 6, serial 5, startup 4, clock 2:0
// - Programmed bits read zero, unprogrammed read one
// - Sequence starts by loading command 0001 0001
// - High address byte 00..01 latched as upper bit
// - Low address byte latched as lower eight bits
// - Data low byte held as write value
// - Byte select low before write strobe
// - Low strobe starts write, ready/busy goes low
// - Programmer waits for ready before next byte
// - Command and address kept through an operation
// - Load command only once for many locations
// - Reload high byte only on new page; the programmer also reloads it after every command load, same page or not
// - Skipping value FF allowed after chip erase
// - Same reuse applies to read sequences
package fle_pkg;
  // Load target codes on the link
  localparam logic [1:0] LD_CMD      = 2'h0;
  localparam logic [1:0] LD_ADDR_HI  = 2'h1;
  localparam logic [1:0] LD_ADDR_LO  = 2'h2;
  localparam logic [1:0] LD_DATA_LO  = 2'h3;
  // Command code for an EEPROM byte write
  localparam logic [7:0] CMD_EE_WRITE = 8'h11;
  // Pointer values selecting the readback source
  localparam logic [15:0] Z_FUSE = 16'h0000;
  localparam logic [15:0] Z_LOCK = 16'h0001;
  // Readback window length in cycles after the control bits are set
  localparam int RB_WINDOW = 3;
  // Control register field positions inside the CPU write word
  localparam int CTL_SELF_PROG_POS = 0;
  localparam int CTL_LOCK_ACC_POS  = 3;
  // Lock byte field positions
  localparam int LOCK_BOOT_LSB = 2;
  localparam int LOCK_MEM_LSB  = 0;
  // Fuse byte field positions
  localparam int FUSE_VEC_POS  = 6;
  localparam int FUSE_SER_POS  = 5;
  localparam int FUSE_SUT_POS  = 4;
  localparam int FUSE_CLK_LSB  = 0;
  // Byte write time, in nanoseconds and in cycles at 4 ns
  localparam int CLK_PERIOD_NS = 4;
  localparam int EE_WRITE_NS   = 64;
  localparam int EE_WRITE_CYC  = (EE_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Programmer register byte offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_ADDR   = 4'h4;
  localparam logic [3:0] REG_DATA   = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hC;
  // Control register bits
  localparam int CTRL_START_POS  = 0;
  localparam int CTRL_RECMD_POS  = 1;
  localparam int CTRL_SKIPFF_POS = 2;
  // Status register bits
  localparam int STAT_BUSY_POS  = 0;
  localparam int STAT_READY_POS = 1;
  localparam int STAT_SKIP_POS  = 2;
  // Reset values
  localparam logic [8:0] ADDR_RST = 9'h000;
  localparam logic [7:0] DATA_RST = 8'hFF;
endpackage : fle_pkg

// ==== rtl/fle_pp_if.sv ====
/*
  Parallel programming link between an external programmer and the
  device. Holds the pins and one modport per end.
  Assumes both ends run on the same clock; pins are synchronous.
*/
`timescale 1ns/1ps
interface fle_pp_if;
  logic [7:0] pp_data;        // Byte to be loaded
  logic       pp_load;        // Load pulse, active high
  logic [1:0] pp_load_sel;    // Load target code
  logic       byte_select;    // Byte select, low picks low data
  logic       pp_wr_n;        // Write strobe, active low
  logic       ready_busy_out; // High ready, low busy
  modport device (input pp_data, input pp_load, input pp_load_sel, input byte_select,
                  input pp_wr_n, output ready_busy_out);
  modport prog   (output pp_data, output pp_load, output pp_load_sel, output byte_select,
                  output pp_wr_n, input ready_busy_out);
endinterface : fle_pp_if

// ==== rtl/fle_prog.sv ====
/*
  Programmer end: classic Wishbone slave registers that order EEPROM
  byte writes, driven over the parallel programming link.
  Assumes the device answers a strobe with ready/busy low next cycle.
*/
// The implementer's own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
module fle_prog (
  input  wire logic        clk_i,    // Clock
  input  wire logic        rst_i,    // Synchronous reset, high
  input  wire logic        ce_i,     // Clock enable
  input  wire logic        cyc_i,    // Wishbone cycle
  input  wire logic        stb_i,    // Wishbone strobe
  input  wire logic        we_i,     // Wishbone write enable
  input  wire logic [3:0]  adr_i,    // Wishbone byte address
  input  wire logic [3:0]  sel_i,    // Wishbone byte selects
  input  wire logic [31:0] dat_i,    // Wishbone write data
  output logic [31:0]      dat_o,    // Wishbone read data
  output logic             ack_o,    // Wishbone acknowledge
  fle_pp_if.prog           pp        // Programming link
);
  typedef enum logic [2:0] {
    FLE_P_IDLE = 3'b000,
    FLE_P_CMD  = 3'b001,
    FLE_P_AHI  = 3'b010,
    FLE_P_ALO  = 3'b011,
    FLE_P_DAT  = 3'b100,
    FLE_P_STB  = 3'b101,
    FLE_P_GAP  = 3'b110,
    FLE_P_WAIT = 3'b111
  } fle_pst_type;

  fle_pst_type pst_q;      // Sequencer state
  logic [8:0]  addr_q;     // Target address
  logic [7:0]  data_q;     // Target data
  logic        go_q;       // Start request
  logic        recmd_q;    // Force command reload
  logic        skipff_q;   // Skip writes of FF
  logic        cmd_ok_q;   // Command already loaded
  logic        hi_ok_q;    // High byte already loaded
  logic        hi_q;       // Last loaded high byte
  logic        skipped_q;  // Last start was skipped
  logic [7:0]  ppd_q;      // Link data flop
  logic        ppl_q;      // Link load flop
  logic [1:0]  pps_q;      // Link target flop
  logic        wrn_q;      // Link strobe flop
  logic        acc;        // Bus access this cycle
  logic        busy;       // Sequencer active

  assign acc  = cyc_i && stb_i && !ack_o;
  assign busy = pst_q != FLE_P_IDLE;
  assign pp.pp_data     = ppd_q;
  assign pp.pp_load     = ppl_q;
  assign pp.pp_load_sel = pps_q;
  assign pp.pp_wr_n     = wrn_q;
  assign pp.byte_select = 1'b0;

  // Bus answer: one wait state, ack one cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      ack_o <= acc;
      dat_o <= 32'h0000_0000;
      if (acc && !we_i)
      begin
        case (adr_i)
          fle_pkg::REG_ADDR:   dat_o <= {23'h000000, addr_q};
          fle_pkg::REG_DATA:   dat_o <= {24'h000000, data_q};
          fle_pkg::REG_STATUS: dat_o <= {29'h00000000, skipped_q, pp.ready_busy_out, busy || go_q};
          default:             dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Register writes; start is refused while busy
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      addr_q   <= fle_pkg::ADDR_RST;
      data_q   <= fle_pkg::DATA_RST;
      go_q     <= 1'b0;
      recmd_q  <= 1'b0;
      skipff_q <= 1'b0;
    end
    else if (ce_i)
    begin
      if (pst_q == FLE_P_IDLE && go_q)
        go_q <= 1'b0;
      if (acc && we_i && !busy && !go_q)
      begin
        case (adr_i)
          fle_pkg::REG_CTRL:
          if (sel_i[0])
          begin
            go_q     <= dat_i[fle_pkg::CTRL_START_POS];
            recmd_q  <= dat_i[fle_pkg::CTRL_RECMD_POS];
            skipff_q <= dat_i[fle_pkg::CTRL_SKIPFF_POS];
          end
          fle_pkg::REG_ADDR:
          begin
            if (sel_i[0]) addr_q[7:0] <= dat_i[7:0];
            if (sel_i[1]) addr_q[8]   <= dat_i[8];
          end
          fle_pkg::REG_DATA:
          if (sel_i[0])
            data_q <= dat_i[7:0];
          default:
            go_q <= go_q;
        endcase
      end
    end
  end

  // Link sequencer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pst_q     <= FLE_P_IDLE;
      cmd_ok_q  <= 1'b0;
      hi_ok_q   <= 1'b0;
      hi_q      <= 1'b0;
      skipped_q <= 1'b0;
      ppd_q     <= 8'h00;
      ppl_q     <= 1'b0;
      pps_q     <= fle_pkg::LD_CMD;
      wrn_q     <= 1'b1;
    end
    else if (ce_i)
    begin
      ppl_q <= 1'b0;
      wrn_q <= 1'b1;
      case (pst_q)
        FLE_P_IDLE:
        if (go_q)
        begin
          skipped_q <= skipff_q && data_q == 8'hFF;
          if (skipff_q && data_q == 8'hFF)
            pst_q <= FLE_P_IDLE;
          else if (recmd_q || !cmd_ok_q)
            pst_q <= FLE_P_CMD;
          else if (!hi_ok_q || hi_q != addr_q[8])
            pst_q <= FLE_P_AHI;
          else
            pst_q <= FLE_P_ALO;
        end
        FLE_P_CMD:
        begin
          ppd_q    <= fle_pkg::CMD_EE_WRITE;
          pps_q    <= fle_pkg::LD_CMD;
          ppl_q    <= 1'b1;
          cmd_ok_q <= 1'b1;
          pst_q    <= FLE_P_AHI;
        end
        FLE_P_AHI:
        begin
          ppd_q   <= {7'h00, addr_q[8]};
          pps_q   <= fle_pkg::LD_ADDR_HI;
          ppl_q   <= 1'b1;
          hi_ok_q <= 1'b1;
          hi_q    <= addr_q[8];
          pst_q   <= FLE_P_ALO;
        end
        FLE_P_ALO:
        begin
          ppd_q <= addr_q[7:0];
          pps_q <= fle_pkg::LD_ADDR_LO;
          ppl_q <= 1'b1;
          pst_q <= FLE_P_DAT;
        end
        FLE_P_DAT:
        begin
          ppd_q <= data_q;
          pps_q <= fle_pkg::LD_DATA_LO;
          ppl_q <= 1'b1;
          pst_q <= FLE_P_STB;
        end
        FLE_P_STB:
        begin
          wrn_q <= 1'b0;
          pst_q <= FLE_P_GAP;
        end
        FLE_P_GAP:
          pst_q <= FLE_P_WAIT;
        FLE_P_WAIT:
        if (pp.ready_busy_out)
          pst_q <= FLE_P_IDLE;
        default:
          pst_q <= FLE_P_IDLE;
      endcase
    end
  end
endmodule : fle_prog

// ==== verif/fle_props.sv ====
/* Checker of the programming link between the two ends.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module fle_props #(
  parameter int WRITE_CYC = 16 // Busy length in cycles
) (
  input wire logic       clk_i,         // Clock
  input wire logic       rst_i,         // Reset
  input wire logic [7:0] pp_data,       // Load byte
  input wire logic       pp_load,       // Load pulse
  input wire logic [1:0] pp_load_sel,   // Load target
  input wire logic       byte_select,   // Byte select
  input wire logic       pp_wr_n,       // Write strobe, low
  input wire logic       ready_busy_out // High when ready
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic       seen_q; // Some load seen since reset
  logic [7:0] low_q;  // Cycles spent busy
  // Note first load and count busy cycles
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      seen_q <= 1'b0;
      low_q  <= 8'h00;
    end
    else
    begin
      seen_q <= seen_q | pp_load;
      low_q  <= ready_busy_out ? 8'h00 : low_q + 8'h01;
    end
  end
  property p_first_cmd;
    pp_load && !seen_q |-> pp_load_sel == fle_pkg::LD_CMD && pp_data == fle_pkg::CMD_EE_WRITE;
  endproperty
  a_first_cmd: assert property (p_first_cmd) else $error("first load not write command");
  property p_hi_range;
    pp_load && pp_load_sel == fle_pkg::LD_ADDR_HI |-> pp_data <= 8'h01;
  endproperty
  a_hi_range: assert property (p_hi_range) else $error("high address out of range");
  property p_data_first;
    !pp_wr_n |-> $past(pp_load) && $past(pp_load_sel) == fle_pkg::LD_DATA_LO;
  endproperty
  a_data_first: assert property (p_data_first) else $error("strobe without data load");
  property p_bs_low;
    !pp_wr_n |-> !byte_select;
  endproperty
  a_bs_low: assert property (p_bs_low) else $error("byte select high at strobe");
  property p_go_busy;
    !pp_wr_n && ready_busy_out |=> !ready_busy_out;
  endproperty
  a_go_busy: assert property (p_go_busy) else $error("strobe did not start busy");
  property p_busy_len;
    $rose(ready_busy_out) |-> low_q == 8'(WRITE_CYC);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  property p_wait_rdy;
    !ready_busy_out |-> pp_wr_n && !pp_load;
  endproperty
  a_wait_rdy: assert property (p_wait_rdy) else $error("link activity while busy");
  property p_idle_rdy;
    ready_busy_out && pp_wr_n |=> ready_busy_out;
  endproperty
  a_idle_rdy: assert property (p_idle_rdy) else $error("busy without strobe");
  c_write: cover property (!pp_wr_n ##1 !ready_busy_out);
  c_done: cover property ($rose(ready_busy_out));
  c_hi: cover property (pp_load && pp_load_sel == fle_pkg::LD_ADDR_HI && pp_data == 8'h01);
endmodule // fle_props

// ==== verif/fuse_lock_read_eeprom_prog_test.sv ====
/* Bench joining both link ends; drives the register bus and the CPU side.
   Assumes the shared package and the link interface. */
`timescale 1ns/1ps
module fuse_lock_read_eeprom_prog_test;
  localparam int WR_CYC = 16; // Byte write time
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o; // Clock, bus
  logic [3:0]  adr_i = 4'h0, sel_i = 4'h0;  // Bus address
  logic [31:0] dat_i = 32'h0, dat_o, rd;    // Bus data, last read
  logic        ctl_wr = 1'b0, program_memory_load_instr = 1'b0, spm = 1'b0, rvalid, lab, spe; // CPU side
  logic [7:0]  ctl_wd = 8'h00, ee_rdata, cpu_rdata;
  logic [15:0] z = 16'h0000;                // Index pointer
  logic [5:0]  lock = 6'h00;                // Lock bits
  logic [6:0]  fuse = 7'h00;                // Fuse bits
  logic [8:0]  raddr = 9'h000, a, last_a;   // Array addresses
  logic [7:0]  mem_exp [int];               // Expected array
  int error_cnt = 0, num_checks = 0, cmd_n = 0, ahi_n = 0, cmd_e, ahi_e;
  fle_pp_if u_fle_pp_if ();
  fle_device #(.WRITE_CYC(WR_CYC)) u_fle_device (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .pp(u_fle_pp_if),
    .cpu_ctl_wr_i(ctl_wr), .cpu_ctl_wdata_i(ctl_wd), .cpu_lpm_i(program_memory_load_instr), .cpu_spm_i(spm), .cpu_z_i(z),
    .lock_prog_i(lock), .fuse_prog_i(fuse), .ee_raddr_i(raddr), .ee_rdata_o(ee_rdata),
    .cpu_rdata_o(cpu_rdata), .cpu_rvalid_o(rvalid), .lock_access_bit_o(lab), .self_prog_enable_o(spe));
  fle_prog u_fle_prog (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pp(u_fle_pp_if));
  fle_props #(.WRITE_CYC(WR_CYC)) u_fle_props (.clk_i(clk_i), .rst_i(rst_i), .pp_data(u_fle_pp_if.pp_data),
    .pp_load(u_fle_pp_if.pp_load), .pp_load_sel(u_fle_pp_if.pp_load_sel), .byte_select(u_fle_pp_if.byte_select),
    .pp_wr_n(u_fle_pp_if.pp_wr_n), .ready_busy_out(u_fle_pp_if.ready_busy_out));
  // 250 MHz clock
  always #2 clk_i = ~clk_i;
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Verdict and end of run
  task automatic wrap_up();
    if (error_cnt == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Count command and high address loads on the link
  always @(negedge clk_i)
  begin
    if (u_fle_pp_if.pp_load && u_fle_pp_if.pp_load_sel == fle_pkg::LD_CMD)
    begin
      cmd_n++;
      chk(u_fle_pp_if.pp_data, fle_pkg::CMD_EE_WRITE, "command code");
    end
    if (u_fle_pp_if.pp_load && u_fle_pp_if.pp_load_sel == fle_pkg::LD_ADDR_HI)
      ahi_n++;
  end
  // One classic bus cycle; read data lands in rd
  task automatic wb(input logic w, input logic [3:0] ad, input logic [3:0] s, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= ad;
    sel_i <= s;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  // Order one byte write; junk rewrites address and data while busy
  task automatic ee_wr(input logic [8:0] ad, input logic [7:0] d, input logic [2:0] c, input logic junk);
    int n;
    wb(1'b1, fle_pkg::REG_ADDR, 4'h3, {23'h0, ad});
    wb(1'b1, fle_pkg::REG_DATA, 4'h1, {24'h0, d});
    wb(1'b1, fle_pkg::REG_CTRL, 4'h1, {29'h0, c});
    n = 0;
    while (junk && u_fle_pp_if.ready_busy_out !== 1'b0 && n < 20)
    begin
      @(negedge clk_i);
      n++;
    end
    if (junk)
    begin
      chk(u_fle_pp_if.ready_busy_out, 1'b0, "busy before junk");
      wb(1'b1, fle_pkg::REG_ADDR, 4'h3, {23'h0, ~ad});
      wb(1'b1, fle_pkg::REG_DATA, 4'h1, {24'h0, ~d});
    end
    n = 0;
    do
    begin
      wb(1'b0, fle_pkg::REG_STATUS, 4'hF, 32'h0);
      n++;
    end
    while (rd[fle_pkg::STAT_BUSY_POS] !== 1'b0 && n < 60);
    chk(rd[fle_pkg::STAT_BUSY_POS], 1'b0, "write finished");
    if (!c[fle_pkg::CTRL_SKIPFF_POS] || d != 8'hFF)
      mem_exp[ad] = d;
  endtask
  // Read back one array byte
  task automatic ee_chk(input logic [8:0] ad);
    @(posedge clk_i);
    raddr <= ad;
    @(posedge clk_i);
    @(negedge clk_i);
    chk(ee_rdata, mem_exp[ad], "array byte");
  endtask
  // CPU readback: k 1..3 load in that cycle, 0 store pulse, 4 nothing
  task automatic rb(input logic [15:0] zv, input int k);
    logic [5:0] lv;
    logic [6:0] fv;
    logic [7:0] e;
    lv = 6'($urandom);
    fv = 7'($urandom);
    e = (zv == fle_pkg::Z_LOCK) ? {2'b11, ~lv} : {1'b1, ~fv[6:4], 1'b1, ~fv[2:0]};
    @(posedge clk_i);
    lock <= lv;
    fuse <= fv;
    z <= zv;
    ctl_wr <= 1'b1;
    ctl_wd <= 8'h09;
    @(posedge clk_i);
    ctl_wr <= 1'b0;
    repeat ((k > 1) ? k - 1 : 0) @(posedge clk_i);
    if (k == 0)
      spm <= 1'b1;
    else if (k < 4)
      program_memory_load_instr <= 1'b1;
    @(posedge clk_i);
    program_memory_load_instr <= 1'b0;
    spm <= 1'b0;
    @(negedge clk_i);
    chk({lab, spe}, 2'b00, "control bits");
    if (k >= 1 && k <= 3)
      chk({rvalid, cpu_rdata}, {1'b1, e}, "readback");
    else
      chk(rvalid, 1'b0, "no readback");
  endtask
  // Main sequence
  initial
  begin
    logic [3:0]  ra [4] = '{fle_pkg::REG_ADDR, fle_pkg::REG_DATA, fle_pkg::REG_STATUS, 4'h2};
    logic [31:0] rv [4] = '{32'h0, 32'hFF, 32'h2, 32'h0};
    logic [8:0]  ca [4] = '{9'h000, 9'h0FF, 9'h100, 9'h1FF};
    logic [7:0]  cd [4] = '{8'h00, 8'hA5, 8'hFF, 8'h5A};
    void'($urandom(1));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk(u_fle_pp_if.ready_busy_out, 1'b1, "ready after reset");
    wb(1'b1, 4'h2, 4'hF, 32'hFFFF_FFFF);
    for (int i = 0; i < 4; i++)
    begin
      wb(1'b0, ra[i], 4'hF, 32'h0);
      chk(rd, rv[i], "reset value");
    end
    // Corner and random writes; command once, high byte on page change
    cmd_e = 1;
    ahi_e = 0;
    for (int i = 0; i < 16; i++)
    begin
      a = (i < 4) ? ca[i] : 9'($urandom);
      if (i == 0 || a[8] != last_a[8])
        ahi_e++;
      last_a = a;
      ee_wr(a, (i < 4) ? cd[i] : 8'($urandom), 3'h1, 1'b0);
      ee_chk(a);
    end
    chk(cmd_n, cmd_e, "command loads");
    chk(ahi_n, ahi_e, "high byte loads");
    foreach (mem_exp[k])
      ee_chk(9'(k));
    // Register writes during busy are ignored
    ee_wr(9'h0AA, 8'h3C, 3'h1, 1'b1);
    wb(1'b0, fle_pkg::REG_ADDR, 4'hF, 32'h0);
    chk(rd, 32'h0AA, "address kept");
    ee_chk(9'h0AA);
    for (int k = 0; k < 5; k++)
      for (int j = 0; j < 2; j++)
        rb(j ? fle_pkg::Z_LOCK : fle_pkg::Z_FUSE, k);
    // Skipped value leaves the byte alone
    ee_wr(9'h033, 8'h77, 3'h1, 1'b0);
    ee_wr(9'h033, 8'hFF, 3'h5, 1'b0);
    chk(rd[fle_pkg::STAT_SKIP_POS], 1'b1, "skip flag");
    ee_chk(9'h033);
    // Forced command reload
    cmd_e = cmd_n + 1;
    ee_wr(9'h044, 8'h12, 3'h3, 1'b0);
    chk(cmd_n, cmd_e, "command reload");
    ee_chk(9'h044);
    wrap_up();
  end
  // Watchdog
  initial
  begin
    repeat (60000) @(posedge clk_i);
    error_cnt++;
    wrap_up();
  end
endmodule // fuse_lock_read_eeprom_prog_test
